// File: hw/fdrs_pkg.sv
// Constants and types for the drive fault reaction selector
// ----------------------------------------------------------------
// ----------------------------------------------------------------
package fdrs_pkg;

    // ------------------------------------------------------------
    // Object indices
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_DEV_REACT = 16'h3700;
    localparam logic [15:0] IDX_LIM_REACT = 16'h3701;
    localparam logic [15:0] IDX_MEM_SIZE = 16'h4012;
    localparam logic [15:0] IDX_HW_SETUP = 16'h4013;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [15:0] RST_DEV_REACT = 16'hffff;
    localparam logic [15:0] RST_LIM_REACT = 16'hffff;
    localparam logic [31:0] RST_MEM_SIZE = 32'h0000_0000;
    localparam logic [31:0] RST_HW_SETUP = 32'h0000_0000;

    // ------------------------------------------------------------
    // Option codes
    // ------------------------------------------------------------
    localparam logic [15:0] CODE_NONE = 16'hffff;
    localparam logic [15:0] CODE_OFF = 16'h0000;
    localparam logic [15:0] CODE_SLOW = 16'h0001;
    localparam logic [15:0] CODE_QUICK = 16'h0002;
    localparam logic [15:0] CODE_SLOW_QS = 16'h0005;
    localparam logic [15:0] CODE_QUICK_QS = 16'h0006;

    // Status word position of the warning flag
    localparam int STAT_WARN_BIT = 7;

    typedef enum logic [1:0] {
        FDRS_RE_NONE = 2'h0,
        FDRS_RE_OFF = 2'h1,
        FDRS_RE_SLOW = 2'h3,
        FDRS_RE_QUICK = 2'h2
    } fdrs_react_e;

    typedef enum logic [1:0] {
        FDRS_SR_KEEP = 2'h0,
        FDRS_SR_SWON_DIS = 2'h1,
        FDRS_SR_QS_ACTIVE = 2'h3
    } fdrs_sreq_e;

endpackage

// File: hw/fdrs_react_if.sv
// Carrier between option code decoder and the selector core
`timescale 1ns/1ps
interface fdrs_react_if;
    import fdrs_pkg::*;
    logic [15:0] code;
    logic is_limit;
    fdrs_react_e react;
    fdrs_sreq_e sreq;
    logic unsup;

    modport dec (
        input code,
        input is_limit,
        output react,
        output sreq,
        output unsup
    );

    modport user (
        output code,
        output is_limit,
        input react,
        input sreq,
        input unsup
    );
endinterface

// File: hw/fdrs_code_decode.sv
// Option code decoder for deviation and limit switch tables
`timescale 1ns/1ps
module fdrs_code_decode
    import fdrs_pkg::*;
(
    fdrs_react_if.dec bus
);

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    always_comb begin
        bus.react = FDRS_RE_NONE;
        bus.sreq = FDRS_SR_KEEP;
        bus.unsup = 1'b0;
        if (!bus.is_limit) begin
            unique case (bus.code)
                CODE_NONE: bus.react = FDRS_RE_NONE;
                CODE_OFF: bus.react = FDRS_RE_OFF;
                CODE_SLOW: bus.react = FDRS_RE_SLOW;
                CODE_QUICK: bus.react = FDRS_RE_QUICK;
                default: bus.unsup = 1'b1;
            endcase
        end else begin
            unique case (bus.code)
                CODE_NONE: bus.react = FDRS_RE_NONE;
                CODE_SLOW: begin
                    bus.react = FDRS_RE_SLOW;
                    bus.sreq = FDRS_SR_SWON_DIS;
                end
                CODE_QUICK: begin
                    bus.react = FDRS_RE_QUICK;
                    bus.sreq = FDRS_SR_SWON_DIS;
                end
                CODE_SLOW_QS: begin
                    bus.react = FDRS_RE_SLOW;
                    bus.sreq = FDRS_SR_QS_ACTIVE;
                end
                CODE_QUICK_QS: begin
                    bus.react = FDRS_RE_QUICK;
                    bus.sreq = FDRS_SR_QS_ACTIVE;
                end
                default: bus.unsup = 1'b1;
            endcase
        end
    end

endmodule

// File: hw/fdrs_top.sv
// Drive fault reaction selector with its object access port
`timescale 1ns/1ps
module fdrs_top
    import fdrs_pkg::*;
#(
    parameter int CODE_W = 16,
    parameter int DATA_W = 32
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    // Object access from the fieldbus side
    input wire logic [15:0] obj_index_i,
    input wire logic obj_rd_i,
    input wire logic obj_wr_i,
    input wire logic [31:0] obj_wdata_i,
    output logic [31:0] obj_rdata_o,
    output logic obj_ack_o,
    output logic obj_err_o,
    // Fault events from the drive logic
    input wire logic dev_err_i,
    input wire logic limit_pass_i,
    input wire logic warn_clear_i,
    // Attached configuration memory
    input wire logic mem_present_i,
    input wire logic [31:0] mem_bytes_i,
    // Reaction commands, code error, warning status and setup word towards the drive
    output logic react_off_o,
    output logic react_slow_o,
    output logic react_quick_o,
    output logic goto_swon_dis_o,
    output logic goto_qs_active_o,
    output logic unsup_code_o,
    output logic [15:0] status_warn_o,
    output logic [31:0] hw_setup_o
);

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // Codes are signed 16-bit objects; other widths break decoding
    if (CODE_W != 16) begin : g_bad_code_w
        $error("fdrs_top: CODE_W must be 16");
    end
    if (DATA_W != 32) begin : g_bad_data_w
        $error("fdrs_top: DATA_W must be 32");
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [15:0] dev_react_q;
    logic [15:0] lim_react_q;
    logic [31:0] mem_size_q;
    logic [31:0] hw_setup_q;
    logic warn_q;
    logic [31:0] rdata_q;
    logic ack_q;
    logic err_q;
    logic react_off_q;
    logic react_slow_q;
    logic react_quick_q;
    logic swon_dis_q;
    logic qs_active_q;
    logic unsup_q;

    logic acc;
    logic hit_dev;
    logic hit_lim;
    logic hit_mem;
    logic hit_hw;
    logic mapped;

    assign acc = obj_rd_i | obj_wr_i;
    assign hit_dev = (obj_index_i == IDX_DEV_REACT);
    assign hit_lim = (obj_index_i == IDX_LIM_REACT);
    assign hit_mem = (obj_index_i == IDX_MEM_SIZE);
    assign hit_hw = (obj_index_i == IDX_HW_SETUP);
    assign mapped = hit_dev | hit_lim | hit_mem | hit_hw;

    // ------------------------------------------------------------
    // Option code and setup word objects
    // ------------------------------------------------------------
    // Codes may change at any time; the value in force at the event
    // cycle is the one decoded
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dev_react_q <= RST_DEV_REACT;
        end else if (obj_wr_i && hit_dev) begin
            dev_react_q <= obj_wdata_i[15:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lim_react_q <= RST_LIM_REACT;
        end else if (obj_wr_i && hit_lim) begin
            lim_react_q <= obj_wdata_i[15:0];
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            hw_setup_q <= RST_HW_SETUP;
        end else if (obj_wr_i && hit_hw) begin
            hw_setup_q <= obj_wdata_i;
        end
    end

    // ------------------------------------------------------------
    // Memory size
    // ------------------------------------------------------------
    // Zero when absent
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            mem_size_q <= RST_MEM_SIZE;
        end else if (mem_present_i) begin
            mem_size_q <= mem_bytes_i;
        end else begin
            mem_size_q <= RST_MEM_SIZE;
        end
    end

    // ------------------------------------------------------------
    // Object read and write answer
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_q <= 1'b0;
            err_q <= 1'b0;
        end else begin
            ack_q <= acc;
            err_q <= acc & (!mapped | (obj_wr_i & hit_mem));
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q <= 32'h0000_0000;
        end else if (obj_rd_i) begin
            if (hit_dev) begin
                rdata_q <= {16'h0000, dev_react_q};
            end else if (hit_lim) begin
                rdata_q <= {16'h0000, lim_react_q};
            end else if (hit_mem) begin
                rdata_q <= mem_size_q;
            end else if (hit_hw) begin
                rdata_q <= hw_setup_q;
            end else begin
                rdata_q <= 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Code decoders
    // ------------------------------------------------------------
    fdrs_react_if dev_if ();
    fdrs_react_if lim_if ();

    assign dev_if.code = dev_react_q;
    assign dev_if.is_limit = 1'b0;
    assign lim_if.code = lim_react_q;
    assign lim_if.is_limit = 1'b1;

    fdrs_code_decode u_dev_dec (
        .bus(dev_if.dec)
    );

    fdrs_code_decode u_lim_dec (
        .bus(lim_if.dec)
    );

    // ------------------------------------------------------------
    // Warning flag
    // ------------------------------------------------------------
    // Set wins over clear
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            warn_q <= 1'b0;
        end else if (limit_pass_i) begin
            warn_q <= 1'b1;
        end else if (warn_clear_i) begin
            warn_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Reaction commands
    // ------------------------------------------------------------
    // A deviation error outranks a limit event in the same cycle,
    // since switching off or braking for it is the safer choice
    fdrs_react_e sel_react;
    fdrs_sreq_e sel_sreq;
    logic sel_unsup;

    always_comb begin
        sel_react = FDRS_RE_NONE;
        sel_sreq = FDRS_SR_KEEP;
        sel_unsup = 1'b0;
        if (dev_err_i) begin
            sel_react = dev_if.react;
            sel_unsup = dev_if.unsup;
        end else if (limit_pass_i) begin
            sel_react = lim_if.react;
            sel_sreq = lim_if.sreq;
            sel_unsup = lim_if.unsup;
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            react_off_q <= 1'b0;
            react_slow_q <= 1'b0;
            react_quick_q <= 1'b0;
        end else begin
            react_off_q <= (sel_react == FDRS_RE_OFF);
            react_slow_q <= (sel_react == FDRS_RE_SLOW);
            react_quick_q <= (sel_react == FDRS_RE_QUICK);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            swon_dis_q <= 1'b0;
            qs_active_q <= 1'b0;
        end else begin
            swon_dis_q <= (sel_sreq == FDRS_SR_SWON_DIS);
            qs_active_q <= (sel_sreq == FDRS_SR_QS_ACTIVE);
        end
    end

    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            unsup_q <= 1'b0;
        end else begin
            unsup_q <= sel_unsup;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign obj_rdata_o = rdata_q;
    assign obj_ack_o = ack_q;
    assign obj_err_o = err_q;
    assign react_off_o = react_off_q;
    assign react_slow_o = react_slow_q;
    assign react_quick_o = react_quick_q;
    assign goto_swon_dis_o = swon_dis_q;
    assign goto_qs_active_o = qs_active_q;
    assign unsup_code_o = unsup_q;
    assign status_warn_o = 16'(warn_q) << STAT_WARN_BIT;
    assign hw_setup_o = hw_setup_q;

endmodule

// File: test/fdrs_sva.sv
// Port checker for the drive fault reaction selector
`timescale 1ns/1ps
module fdrs_sva
    import fdrs_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [15:0] obj_index_i,
    input wire logic obj_wr_i,
    input wire logic [31:0] obj_wdata_i,
    input wire logic obj_ack_o,
    input wire logic obj_err_o,
    input wire logic dev_err_i,
    input wire logic limit_pass_i,
    input wire logic warn_clear_i,
    input wire logic react_off_o,
    input wire logic react_slow_o,
    input wire logic react_quick_o,
    input wire logic goto_swon_dis_o,
    input wire logic goto_qs_active_o,
    input wire logic unsup_code_o,
    input wire logic [15:0] status_warn_o
);
    logic [15:0] dev_q;
    logic [15:0] lim_q;
    logic lim_only;
    logic any_react;
    assign lim_only = limit_pass_i && !dev_err_i;
    assign any_react = react_off_o || react_slow_o || react_quick_o;
    // ------------------------------------------------------------
    // Shadow codes, so each event can be tied to its code
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dev_q <= RST_DEV_REACT;
        end else if (obj_wr_i && obj_index_i == IDX_DEV_REACT) begin
            dev_q <= obj_wdata_i[15:0];
        end
    end
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lim_q <= RST_LIM_REACT;
        end else if (obj_wr_i && obj_index_i == IDX_LIM_REACT) begin
            lim_q <= obj_wdata_i[15:0];
        end
    end
    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_ro_write_err: assert property (
        obj_wr_i && obj_index_i == IDX_MEM_SIZE |=> obj_ack_o && obj_err_o)
        else $error("size object write not refused");
    a_dev_off: assert property (
        dev_err_i && dev_q == CODE_OFF |=> react_off_o && !react_slow_o)
        else $error("deviation code 0 gave no stage off");
    a_dev_none: assert property (
        dev_err_i && !limit_pass_i && dev_q == CODE_NONE
        |=> !any_react && !unsup_code_o)
        else $error("deviation code -1 gave a pulse");
    a_dev_slow: assert property (
        dev_err_i && dev_q == CODE_SLOW |=> react_slow_o && !goto_swon_dis_o)
        else $error("deviation code 1 gave no slow ramp");
    a_warn_set: assert property (
        limit_pass_i |=> status_warn_o == 16'h0080)
        else $error("warning not set after limit pass");
    a_warn_hold: assert property (
        status_warn_o[7] && !warn_clear_i |=> status_warn_o[7])
        else $error("warning dropped without clear");
    a_lim_swon: assert property (
        lim_only && (lim_q == CODE_SLOW || lim_q == CODE_QUICK)
        |=> goto_swon_dis_o && !goto_qs_active_o)
        else $error("limit code 1 or 2 gave wrong state");
    a_lim_qs: assert property (
        lim_only && lim_q == CODE_QUICK_QS
        |=> react_quick_o && goto_qs_active_o && !goto_swon_dis_o)
        else $error("limit code 6 gave wrong reaction");
    a_lim_none: assert property (
        lim_only && lim_q == CODE_NONE |=> !any_react && !goto_swon_dis_o)
        else $error("limit code -1 gave a motion pulse");
    a_react_cause: assert property (
        any_react |-> $past(dev_err_i) || $past(limit_pass_i))
        else $error("reaction pulse without an event");
    a_unsup_quiet: assert property (
        unsup_code_o |-> !any_react && !goto_qs_active_o)
        else $error("reserved code gave a reaction");
    cover property (dev_err_i && dev_q == CODE_OFF);
    cover property (lim_only && lim_q == CODE_SLOW_QS);
    cover property (obj_ack_o && obj_err_o);
endmodule
bind fdrs_top fdrs_sva i_sva (
    .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .obj_index_i(obj_index_i),
    .obj_wr_i(obj_wr_i), .obj_wdata_i(obj_wdata_i), .obj_ack_o(obj_ack_o),
    .obj_err_o(obj_err_o), .dev_err_i(dev_err_i),
    .limit_pass_i(limit_pass_i), .warn_clear_i(warn_clear_i),
    .react_off_o(react_off_o), .react_slow_o(react_slow_o),
    .react_quick_o(react_quick_o), .goto_swon_dis_o(goto_swon_dis_o),
    .goto_qs_active_o(goto_qs_active_o), .unsup_code_o(unsup_code_o),
    .status_warn_o(status_warn_o));

// File: test/fdrs_master.sv
// Fieldbus master model for the object access port
`timescale 1ns/1ps
module fdrs_master (
    input wire logic core_clk_i,
    output logic [15:0] obj_index_o,
    output logic obj_rd_o,
    output logic obj_wr_o,
    output logic [31:0] obj_wdata_o,
    input wire logic [31:0] obj_rdata_i,
    input wire logic obj_ack_i,
    input wire logic obj_err_i
);
    initial begin
        obj_index_o = 16'h0000;
        obj_rd_o = 1'b0;
        obj_wr_o = 1'b0;
        obj_wdata_o = 32'h0000_0000;
    end
    // One-edge request pulse, answer taken in the cycle after
    task automatic xfer(input logic w, input logic [15:0] i,
        input logic [31:0] d, output logic [31:0] r, output logic e,
        output logic a);
        @(negedge core_clk_i);
        obj_index_o = i;
        obj_wdata_o = d;
        obj_rd_o = !w;
        obj_wr_o = w;
        @(negedge core_clk_i);
        obj_rd_o = 1'b0;
        obj_wr_o = 1'b0;
        // Released lines flip, so a stale value cannot pass
        obj_index_o = ~i;
        obj_wdata_o = ~d;
        r = obj_rdata_i;
        e = obj_err_i;
        a = obj_ack_i;
    endtask
endmodule

// File: test/tb_drive_fault_reaction_select.sv
// Self-checking bench for the drive fault reaction selector
`timescale 1ns/1ps
module tb_drive_fault_reaction_select;
    import fdrs_pkg::*;
    logic core_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic dev_err_i = 1'b0;
    logic limit_pass_i = 1'b0;
    logic warn_clear_i = 1'b0;
    logic mem_present_i = 1'b0;
    logic [31:0] mem_bytes_i = 32'h0000_0000;
    logic [15:0] idx;
    logic rd, wr, ack, err, gerr, gack;
    logic [31:0] wdat, rdat, got, hw, hw_exp, rnd;
    logic [5:0] pulses;
    logic [15:0] warn;
    int fails = 0;
    int total_checks = 0;
    int seed = 32'h022bf800;
    int dev_codes[6] = '{-1, 0, 1, 2, 3, 32767};
    int lim_codes[8] = '{-1, 0, 1, 2, 3, 4, 5, 6};
    always #20 core_clk_i = ~core_clk_i;
    fdrs_top i_dut (
        .core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .obj_index_i(idx),
        .obj_rd_i(rd), .obj_wr_i(wr), .obj_wdata_i(wdat),
        .obj_rdata_o(rdat), .obj_ack_o(ack), .obj_err_o(err),
        .dev_err_i(dev_err_i), .limit_pass_i(limit_pass_i),
        .warn_clear_i(warn_clear_i), .mem_present_i(mem_present_i),
        .mem_bytes_i(mem_bytes_i), .react_off_o(pulses[5]),
        .react_slow_o(pulses[4]), .react_quick_o(pulses[3]),
        .goto_swon_dis_o(pulses[2]), .goto_qs_active_o(pulses[1]),
        .unsup_code_o(pulses[0]), .status_warn_o(warn), .hw_setup_o(hw));
    fdrs_master i_master (
        .core_clk_i(core_clk_i), .obj_index_o(idx), .obj_rd_o(rd),
        .obj_wr_o(wr), .obj_wdata_o(wdat), .obj_rdata_i(rdat),
        .obj_ack_i(ack), .obj_err_i(err));
    // ------------------------------------------------------------
    // Reference model and helpers
    // ------------------------------------------------------------
    // reaction table
    function automatic logic [5:0] react_of(input bit lim, input int c);
        case (c)
            -1: return 6'h00;
            0: return lim ? 6'h01 : 6'h20;
            1: return lim ? 6'h14 : 6'h10;
            2: return lim ? 6'h0c : 6'h08;
            5: return lim ? 6'h12 : 6'h01;
            6: return lim ? 6'h0a : 6'h01;
            default: return 6'h01;
        endcase
    endfunction
    task automatic check(input logic [31:0] g, input logic [31:0] e,
        input string m);
        total_checks++;
        if (g !== e) begin
            fails++;
            $display("ERROR %0t %s got %h exp %h", $time, m, g, e);
        end
    endtask
    task automatic acc(input logic w, input logic [15:0] i,
        input logic [31:0] d, input logic [31:0] er, input logic ee);
        i_master.xfer(w, i, d, got, gerr, gack);
        check({31'h0, gack}, 32'h1, "ack");
        check({31'h0, gerr}, {31'h0, ee}, "err");
        if (!w) check(got, er, "read data");
    endtask
    task automatic fire(input logic d, input logic l, input logic [5:0] e);
        @(negedge core_clk_i);
        dev_err_i = d;
        limit_pass_i = l;
        @(negedge core_clk_i);
        dev_err_i = 1'b0;
        limit_pass_i = 1'b0;
        check({26'h0, pulses}, {26'h0, e}, "reaction");
        if (l) check({16'h0, warn}, 32'h80, "warning");
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        mem_bytes_i = $random(seed);
        repeat (3) @(posedge core_clk_i);
        @(negedge core_clk_i);
        rst_n_i = 1'b1;
        acc(1'b0, IDX_DEV_REACT, 0, 32'h0000ffff, 1'b0);
        acc(1'b0, IDX_LIM_REACT, 0, 32'h0000ffff, 1'b0);
        acc(1'b0, IDX_MEM_SIZE, 0, 32'h0, 1'b0);
        acc(1'b0, IDX_HW_SETUP, 0, 32'h0, 1'b0);
        acc(1'b0, 16'h4014, 0, 32'h0, 1'b1);
        $display("test reset_values done");
        mem_present_i = 1'b1;
        mem_bytes_i = $random(seed);
        acc(1'b0, IDX_MEM_SIZE, 0, mem_bytes_i, 1'b0);
        acc(1'b1, IDX_MEM_SIZE, ~mem_bytes_i, 0, 1'b1);
        acc(1'b0, IDX_MEM_SIZE, 0, mem_bytes_i, 1'b0);
        mem_present_i = 1'b0;
        acc(1'b0, IDX_MEM_SIZE, 0, 32'h0, 1'b0);
        hw_exp = $random(seed);
        acc(1'b1, IDX_HW_SETUP, hw_exp, 0, 1'b0);
        acc(1'b0, IDX_HW_SETUP, 0, hw_exp, 1'b0);
        check(hw, hw_exp, "setup word out");
        $display("test objects done");
        foreach (dev_codes[k]) begin
            rnd = $random(seed);
            rnd[15:0] = 16'(dev_codes[k]);
            acc(1'b1, IDX_DEV_REACT, rnd, 32'h0, 1'b0);
            acc(1'b0, IDX_DEV_REACT, 32'h0, {16'h0, rnd[15:0]}, 1'b0);
            fire(1'b1, 1'b0, react_of(1'b0, dev_codes[k]));
        end
        $display("test deviation done");
        foreach (lim_codes[k]) begin
            rnd = $random(seed);
            rnd[15:0] = 16'(lim_codes[k]);
            acc(1'b1, IDX_LIM_REACT, rnd, 32'h0, 1'b0);
            acc(1'b0, IDX_LIM_REACT, 32'h0, {16'h0, rnd[15:0]}, 1'b0);
            fire(1'b0, 1'b1, react_of(1'b1, lim_codes[k]));
            check({16'h0, warn}, 32'h80, "warning held");
            warn_clear_i = 1'b1;
            @(negedge core_clk_i);
            warn_clear_i = 1'b0;
            check({16'h0, warn}, 32'h0, "warning clear");
        end
        $display("test limit done");
        fire(1'b1, 1'b1, 6'h01);
        $display("test both done");
        // Mid-run reset must clear the flag and restore both codes
        rst_n_i = 1'b0;
        @(negedge core_clk_i);
        check({16'h0, warn}, 32'h0, "warning in reset");
        check(hw | rdat, 32'h0, "words in reset");
        check({26'h0, pulses}, 32'h0, "pulses in reset");
        rst_n_i = 1'b1;
        acc(1'b0, IDX_DEV_REACT, 32'h0, 32'h0000ffff, 1'b0);
        acc(1'b0, IDX_LIM_REACT, 32'h0, 32'h0000ffff, 1'b0);
        fire(1'b1, 1'b0, react_of(1'b0, -1));
        $display("test mid_reset done");
        test_done();
    end
    initial begin
        #100us;
        fails++;
        test_done();
    end
endmodule
